// >>> smcrc_core.sv
// CRC check of received SPI commands and CRC generation for responses.
// Assumes the SPI shifter gives one-cycle bit strobes, MSB first, framed by cs_active_i.
//
// What this block does
// - 8-bit CRC over all 32 command bits, MSB first in arrival order.
// - Failing command is discarded and answered with the error response.
// - Check register preloaded with seed; whole message shifted in MSB first.
// - Zero residue after the last bit passes; non-zero fails.
// - 8-bit mode polynomial is x^8+x^5+x^3+x^2+x+1.
// - 8-bit seed is FF for field zero, else F concatenated with field.
// - Response CRC generated over all 32 response bits, MSB first.
// - Generator shifts message then eight zeros; register holds the CRC.
// - CRC-length option selects 4-bit CRC instead of 8-bit.
// - 4-bit mode polynomial is x^4+1, seed taken from field directly.
// - 4-bit response generation shifts four zeros after the message.
`timescale 1ns/1ps
module smcrc_core
    import smcrc_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         resetn_i,
    input  wire logic         crc4_mode_i,
    input  wire logic [3:0]   crc_seed_nibble_i,
    input  wire logic         cs_active_i,
    input  wire logic         rx_bit_valid_i,
    input  wire logic         rx_bit_i,
    input  wire logic         tx_start_i,
    input  wire logic [31:0]  tx_msg_i,
    output smcrc_check_s      check_o,
    output logic              cmd_execute_o,
    output logic              cmd_error_o,
    output logic [7:0]        tx_crc_o,
    output logic              tx_crc_valid_o,
    output logic              tx_busy_o
);

    // seed select; direct seed in 4-bit mode
    function automatic logic [7:0] seed_of(input logic m4, input logic [3:0] f);
        if (m4)
            return {4'h0, f};
        else if (f == SEED_ZERO)
            return SEED8_ALLONES;
        else
            return {SEED8_UPPER, f};
    endfunction : seed_of

    // one serial CRC step, bit entering the low end
    function automatic logic [7:0] crc_step(input logic m4, input logic [7:0] r,
                                            input logic b);
        logic fb;
        fb = 1'b0;
        if (m4) begin
            fb = r[3];
            return {4'h0, r[2:0], b} ^ (fb ? {4'h0, POLY4} : 8'h00);
        end
        fb = r[7];
        return {r[6:0], b} ^ (fb ? POLY8 : 8'h00);
    endfunction : crc_step

    logic [7:0] rx_crc_q;
    logic [5:0] rx_cnt_q;
    logic       cs_q;
    logic       frame_start;
    logic       m4_q;

    assign frame_start = cs_active_i && !cs_q;

    always_ff @(posedge clock_i) begin
        if (!resetn_i)
            cs_q <= 1'b0;
        else
            cs_q <= cs_active_i;
    end

    // mode latched per frame so a change mid-frame cannot corrupt it
    always_ff @(posedge clock_i) begin
        if (!resetn_i)
            m4_q <= 1'b0;
        else if (frame_start)
            m4_q <= crc4_mode_i;
    end

    // restart from seed on each frame
    // shift every received bit, CRC field included
    // count all 32 bits MSB first
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rx_crc_q <= CRC_RESET;
            rx_cnt_q <= CNT_RESET;
        end else if (frame_start) begin
            rx_crc_q <= seed_of(crc4_mode_i, crc_seed_nibble_i);
            rx_cnt_q <= CNT_RESET;
            if (rx_bit_valid_i) begin
                rx_crc_q <= crc_step(crc4_mode_i,
                                     seed_of(crc4_mode_i, crc_seed_nibble_i), rx_bit_i);
                rx_cnt_q <= 6'd1;
            end
        end else if (cs_active_i && rx_bit_valid_i && rx_cnt_q < 6'(MSG_BITS + 1)) begin
            rx_crc_q <= crc_step(m4_q, rx_crc_q, rx_bit_i);
            rx_cnt_q <= rx_cnt_q + 6'd1;
        end
    end

    // verdict only at frame end with exactly 32 bits
    // failure suppresses execution and raises the error response
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            check_o       <= '0;
            cmd_execute_o <= 1'b0;
            cmd_error_o   <= 1'b0;
        end else begin
            check_o.valid <= 1'b0;
            cmd_execute_o <= 1'b0;
            cmd_error_o   <= 1'b0;
            if (cs_q && !cs_active_i && rx_cnt_q == 6'(MSG_BITS)) begin
                check_o.valid   <= 1'b1;
                check_o.pass    <= (rx_crc_q == CRC_RESET);
                check_o.residue <= rx_crc_q;
                cmd_execute_o   <= (rx_crc_q == CRC_RESET);
                cmd_error_o     <= (rx_crc_q != CRC_RESET);
            end
        end
    end

    smcrc_gen_e  gen_q;
    logic [31:0] tx_sh_q;
    logic [5:0]  tx_cnt_q;
    logic [7:0]  tx_crc_q;
    logic        tx_m4_q;

    assign tx_busy_o = (gen_q == SMCRC_MSG) || (gen_q == SMCRC_PAD);

    // response message MSB first, one bit a cycle
    // then eight zeros; four zeros in 4-bit mode
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            gen_q          <= SMCRC_IDLE;
            tx_sh_q        <= '0;
            tx_cnt_q       <= CNT_RESET;
            tx_crc_q       <= CRC_RESET;
            tx_m4_q        <= 1'b0;
            tx_crc_o       <= CRC_RESET;
            tx_crc_valid_o <= 1'b0;
        end else begin
            tx_crc_valid_o <= 1'b0;
            case (gen_q)
                SMCRC_IDLE, SMCRC_DONE: begin
                    gen_q <= SMCRC_IDLE;
                    if (tx_start_i) begin
                        tx_sh_q  <= tx_msg_i;
                        tx_crc_q <= seed_of(crc4_mode_i, crc_seed_nibble_i);
                        tx_m4_q  <= crc4_mode_i;
                        tx_cnt_q <= CNT_RESET;
                        gen_q    <= SMCRC_MSG;
                    end
                end
                SMCRC_MSG: begin
                    tx_crc_q <= crc_step(tx_m4_q, tx_crc_q, tx_sh_q[31]);
                    tx_sh_q  <= {tx_sh_q[30:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q + 6'd1;
                    if (tx_cnt_q == 6'(MSG_BITS - 1)) begin
                        tx_cnt_q <= CNT_RESET;
                        gen_q    <= SMCRC_PAD;
                    end
                end
                SMCRC_PAD: begin
                    tx_crc_q <= crc_step(tx_m4_q, tx_crc_q, 1'b0);
                    tx_cnt_q <= tx_cnt_q + 6'd1;
                    if (tx_cnt_q == (tx_m4_q ? 6'(CRC4_BITS - 1) : 6'(CRC8_BITS - 1))) begin
                        tx_crc_o       <= crc_step(tx_m4_q, tx_crc_q, 1'b0);
                        tx_crc_valid_o <= 1'b1;
                        gen_q          <= SMCRC_DONE;
                    end
                end
                default: gen_q <= SMCRC_IDLE;
            endcase
        end
    end

    // Assertions
    property p_exec_pass;
        @(posedge clock_i) disable iff (!resetn_i)
        cmd_execute_o |-> check_o.valid && check_o.residue == 8'h00;
    endproperty
    a_exec_pass: assert property (p_exec_pass) else $error("execute with nonzero residue");

    property p_err_excl;
        @(posedge clock_i) disable iff (!resetn_i)
        cmd_error_o |-> !cmd_execute_o && !check_o.pass;
    endproperty
    a_err_excl: assert property (p_err_excl) else $error("failed command executed");

    property p_only32;
        @(posedge clock_i) disable iff (!resetn_i)
        (cs_q && !cs_active_i && rx_cnt_q != 6'd32) |=> !check_o.valid;
    endproperty
    a_only32: assert property (p_only32) else $error("verdict on short frame");

    property p_seed8;
        @(posedge clock_i) disable iff (!resetn_i)
        (frame_start && !rx_bit_valid_i && !crc4_mode_i && crc_seed_nibble_i == 4'h0)
        |=> rx_crc_q == 8'hFF;
    endproperty
    a_seed8: assert property (p_seed8) else $error("8-bit zero seed not FF");

    property p_seed4;
        @(posedge clock_i) disable iff (!resetn_i)
        (frame_start && !rx_bit_valid_i && crc4_mode_i)
        |=> rx_crc_q == {4'h0, $past(crc_seed_nibble_i)};
    endproperty
    a_seed4: assert property (p_seed4) else $error("4-bit seed wrong");

    property p_gen8_len;
        @(posedge clock_i) disable iff (!resetn_i)
        (gen_q == SMCRC_IDLE && tx_start_i && !crc4_mode_i) |-> ##41 tx_crc_valid_o;
    endproperty
    a_gen8_len: assert property (p_gen8_len) else $error("8-bit CRC not after 40 shifts");

    property p_gen4_len;
        @(posedge clock_i) disable iff (!resetn_i)
        (gen_q == SMCRC_IDLE && tx_start_i && crc4_mode_i) |-> ##37 tx_crc_valid_o;
    endproperty
    a_gen4_len: assert property (p_gen4_len) else $error("4-bit CRC not after 36 shifts");

    property p_poly8;
        @(posedge clock_i) disable iff (!resetn_i)
        (gen_q == SMCRC_PAD && !tx_m4_q && tx_crc_q[7])
        |=> tx_crc_q == (({$past(tx_crc_q[6:0]), 1'b0}) ^ 8'h2F);
    endproperty
    a_poly8: assert property (p_poly8) else $error("8-bit polynomial feedback wrong");

    property p_busy;
        @(posedge clock_i) disable iff (!resetn_i)
        (gen_q == SMCRC_IDLE && tx_start_i) |=> tx_busy_o [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("generator not busy on message");

endmodule : smcrc_core

// >>> smcrc_pkg.sv
// Package for the SPI message CRC checker and generator.
// Assumes a single 100 MHz clock and bit-serial message framing.
package smcrc_pkg;

    localparam int unsigned MSG_BITS      = 32;
    localparam int unsigned CRC8_BITS     = 8;
    localparam int unsigned CRC4_BITS     = 4;
    localparam logic [7:0]  POLY8         = 8'h2F;
    localparam logic [3:0]  POLY4         = 4'h1;
    localparam logic [3:0]  SEED_ZERO     = 4'h0;
    localparam logic [7:0]  SEED8_ALLONES = 8'hFF;
    localparam logic [3:0]  SEED8_UPPER   = 4'hF;
    localparam logic [5:0]  CNT_RESET     = 6'h00;
    localparam logic [7:0]  CRC_RESET     = 8'h00;

    typedef enum logic [1:0] {
        SMCRC_IDLE,
        SMCRC_MSG,
        SMCRC_PAD,
        SMCRC_DONE
    } smcrc_gen_e;

    typedef struct packed {
        logic       valid;
        logic       pass;
        logic [7:0] residue;
    } smcrc_check_s;

endpackage : smcrc_pkg

// >>> smcrc_host.sv
// Host model: shifts 32-bit commands into the checker one bit at a time.
// Assumes the bench has already put the CRC into each command word.
`timescale 1ns/1ps
module smcrc_host (
    input  wire logic clock_i,
    output logic      cs_o,
    output logic      strobe_o,
    output logic      bit_o
);
    initial begin
        cs_o = 1'b0;
        strobe_o = 1'b0;
        bit_o = 1'b0;
    end

    task automatic send(input logic [31:0] w, input int gap, input int nb, input bit lead);
        // optional select cycle before the first bit, so the reseed is seen alone
        if (lead) begin
            @(posedge clock_i);
            cs_o <= 1'b1;
        end
        for (int i = 0; i < nb; i++) begin
            @(posedge clock_i);
            cs_o <= 1'b1;
            strobe_o <= 1'b1;
            bit_o <= (i < 32) ? w[31 - i] : ~bit_o;
            repeat (gap) begin
                @(posedge clock_i);
                strobe_o <= 1'b0;
                bit_o <= ~bit_o;
            end
        end
        // Idle line toggles so a stale bit never looks like data
        @(posedge clock_i);
        cs_o <= 1'b0;
        strobe_o <= 1'b0;
        bit_o <= ~bit_o;
    endtask : send
endmodule : smcrc_host

// >>> smcrc_tb.sv
// Self-checking bench for the SPI message CRC checker and generator.
// Assumes the host model drives the receive side of the core.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench
    import smcrc_pkg::*;
;
    logic         clock_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic         crc4_mode_i = 1'b0;
    logic [3:0]   crc_seed_nibble_i = 4'h0;
    logic         tx_start_i = 1'b0;
    logic [31:0]  tx_msg_i = 32'h0000_0000;
    logic         cs_w, strobe_w, bit_w;
    smcrc_check_s check_o;
    logic         cmd_execute_o, cmd_error_o, tx_crc_valid_o, tx_busy_o;
    logic [7:0]   tx_crc_o;
    int           n_errors = 0;
    int           checks_done = 0;
    int           cycles = 0;
    bit           lead_t = 1'b0;
    logic [31:0]  rng = 32'h3c02_47fc;
    logic [31:0]  examples [7] = '{32'h8022_C1BD, 32'h401F_C157, 32'hC022_0066,
        32'h601F_C1B8, 32'h40FF_5AE5, 32'hC03E_0013, 32'h60FF_5A0A};

    smcrc_host host (.clock_i(clock_i), .cs_o(cs_w), .strobe_o(strobe_w), .bit_o(bit_w));
    smcrc_core dut (.clock_i(clock_i), .resetn_i(resetn_i), .crc4_mode_i(crc4_mode_i),
        .crc_seed_nibble_i(crc_seed_nibble_i), .cs_active_i(cs_w), .rx_bit_valid_i(strobe_w),
        .rx_bit_i(bit_w), .tx_start_i(tx_start_i), .tx_msg_i(tx_msg_i), .check_o(check_o),
        .cmd_execute_o(cmd_execute_o), .cmd_error_o(cmd_error_o), .tx_crc_o(tx_crc_o),
        .tx_crc_valid_o(tx_crc_valid_o), .tx_busy_o(tx_busy_o));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    function logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    function logic [7:0] shift_f(logic [31:0] m, logic m4, logic [3:0] sd, int n);
        logic [7:0] r;
        logic       b;
        r = m4 ? {4'h0, sd} : ((sd == 4'h0) ? 8'hFF : {4'hF, sd});
        for (int i = 0; i < n; i++) begin
            b = (i < 32) ? m[31 - i] : 1'b0;
            if (m4) r = {4'h0, r[2:0], b} ^ (r[3] ? {4'h0, POLY4} : 8'h00);
            else r = {r[6:0], b} ^ (r[7] ? POLY8 : 8'h00);
        end
        return r;
    endfunction : shift_f

    task report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic frame(logic [31:0] w, logic m4, logic [3:0] sd, int nb, logic expv);
        logic       seen;
        logic [7:0] res;
        @(posedge clock_i);
        crc4_mode_i <= m4;
        crc_seed_nibble_i <= sd;
        lead_t = ~lead_t;
        host.send(w, int'(rnd() % 3), nb, lead_t);
        res = shift_f(w, m4, sd, 32);
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            @(posedge clock_i);
            #1;
            seen = (check_o.valid === 1'b1);
        end
        `CHK("verdict", expv, seen)
        if (seen) begin
            `CHK("pass", res == 8'h00, check_o.pass)
            `CHK("execute", res == 8'h00, cmd_execute_o)
            `CHK("error", res != 8'h00, cmd_error_o)
            `CHK("residue", m4 ? res[3:0] : res, m4 ? check_o.residue[3:0] : check_o.residue)
        end
    endtask : frame

    task automatic tx_run(logic [31:0] m, logic m4, logic [3:0] sd);
        int n;
        @(posedge clock_i);
        tx_start_i <= 1'b1;
        tx_msg_i <= m;
        crc4_mode_i <= m4;
        crc_seed_nibble_i <= sd;
        @(posedge clock_i);
        tx_start_i <= 1'b0;
        tx_msg_i <= ~m;
        // Second start while busy must be ignored
        @(posedge clock_i);
        tx_start_i <= 1'b1;
        @(posedge clock_i);
        tx_start_i <= 1'b0;
        #1;
        `CHK("busy", 1'b1, tx_busy_o)
        for (n = 3; n < 60; n++) begin
            @(posedge clock_i);
            #1;
            if (tx_crc_valid_o === 1'b1) break;
        end
        // Edges from the taking edge to the edge that raises the pulse
        `CHK("latency", int'(MSG_BITS + (m4 ? CRC4_BITS : CRC8_BITS)), n)
        `CHK("tx crc", shift_f(m, m4, sd, m4 ? 36 : 40), tx_crc_o)
    endtask : tx_run

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] w;
        logic [31:0] r;
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        `CHK("reset check", 10'h000, check_o)
        `CHK("reset crc", 8'h00, tx_crc_o)
        foreach (examples[i]) frame(examples[i], 1'b0, 4'h0, 32, 1'b1);
        repeat (40) begin
            r = rnd();
            w = rnd();
            w[27:24] = 4'h0;
            w[7:0] = shift_f({w[31:8], 8'h00}, r[0], r[7:4], 32);
            if (r[9:8] == 2'b00) w[r[14:10]] = ~w[r[14:10]];
            frame(w, r[0], r[7:4], 32, 1'b1);
        end
        frame(rnd(), 1'b0, 4'h3, 31, 1'b0);
        frame(rnd(), 1'b1, 4'h5, 33, 1'b0);
        repeat (8) begin
            r = rnd();
            tx_run(rnd(), r[0], r[7:4]);
        end
        report_and_stop();
    end
endmodule : testbench
